// ---- rtl/tsp_defs.svh ----
`ifndef TSP_DEFS_SVH
`define TSP_DEFS_SVH

// Clock and timing
`define TSP_SYS_CLK_KHZ     40000
`define TSP_CONV_TIME_MS    228
`define TSP_HOST_GAP_NS     160
`define TSP_CONV_CYCLES     (`TSP_CONV_TIME_MS * `TSP_SYS_CLK_KHZ)

// Serial frame geometry
`define TSP_WORD_BITS       16
`define TSP_PHASE_BITS      16
`define TSP_CODE_BITS       8
`define TSP_TEMP_BITS       14

// Mode codes
`define TSP_CODE_CONT       8'h00
`define TSP_CODE_SHDN       8'hFF

// Avalon register byte addresses
`define TSP_ADDR_SAMPLE     4'h0
`define TSP_ADDR_STATUS     4'h4
`define TSP_ADDR_RESULT     4'h8
`define TSP_ADDR_WIDTH      4

// Status field positions
`define TSP_ST_SHDN         0
`define TSP_ST_VALID        1
`define TSP_ST_BUSY         2
`define TSP_ST_SEL          3

// Reset and identity values
`define TSP_SAMPLE_RST      14'h0000
`define TSP_RESULT_RST      14'h0000
`define TSP_ID_WORD         16'h2C03  // Arbitrary identity value

`endif

// ---- rtl/tsp_pkg.sv ----
package tsp_pkg;

  // Operating mode, one-hot
  typedef enum logic [1:0] {
    MODE_CONT = 2'b01,
    MODE_SHDN = 2'b10
  } mode_e;

  // Whole state of the serial port block
  typedef struct packed {
    logic [2:0]  cs_s;
    logic [2:0]  ck_s;
    logic [2:0]  di_s;
    logic        cs_f;
    logic        ck_f;
    logic [4:0]  bit_cnt;
    logic [15:0] tx_sr;
    logic [7:0]  rx_sr;
    logic [4:0]  rx_cnt;
    logic        reload_pend;
    mode_e       mode;
    logic        valid;
    logic        busy;
    logic [23:0] conv_cnt;
    logic [13:0] result;
    logic [13:0] sample;
    logic        sio_out;
    logic        sio_oe;
    logic [31:0] rdata;
    logic        waitreq;
  } state_s;

endpackage : tsp_pkg

// ---- rtl/temp_sensor_serial_port.sv ----
`timescale 1ns/100ps
`include "tsp_defs.svh"

// Operation
// (R1) Output changes on falling, input sampled rising
// (R2) Host frames each transfer with select
// (R3) Host keeps select high 160 ns minimum
// (R4) Read is 16 clocks, read/write 32
// (R5) Data line released while select high
// (R6) Host avoids select fall on rising clock
// (R7) First bit driven as select falls
// (R8) Early select release ends transfer cleanly
// (R9) Conversion finishes; load after select high
// (R10) Receive phase follows sixteenth clock, 16 long
// (R11) Eight-bit shift in, last eight decoded
// (R12) FF selects shutdown, 00 continuous conversion
// (R13) Host sends only 00 or FF
// (R14) Reset into continuous mode, result invalid
// (R15) Reads anytime return last result, no abort
// (R16) Read end reloads output, starts conversion; code converts back to back in continuous mode instead
// (R17) Conversion takes up to 228 ms
// (R18) Fourteen-bit two's complement temperature
// (R19) Most significant byte and bit first
// (R20) Port stays active in shutdown
// (R21) Shutdown reads return fixed identity word
// (R22) Read, shutdown, identity, conversion in one frame
// (R23) Two lowest bits always read as one
module temp_sensor_serial_port #(
  parameter int          CONV_CYCLES = `TSP_CONV_CYCLES,
  parameter logic [15:0] ID_WORD     = `TSP_ID_WORD  // Arbitrary identity value
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        CS_N,
  input  wire logic        SERIAL_CLOCK,
  input  wire logic        SIO_IN,
  output logic             SIO_OUT,
  output logic             SIO_OE,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST
);

  localparam logic [23:0] CONV_LAST = 24'(CONV_CYCLES - 1);
  localparam logic [4:0]  PHASE     = 5'(`TSP_PHASE_BITS);
  localparam logic [4:0]  CODE_MIN  = 5'(`TSP_CODE_BITS);

  tsp_pkg::state_s st_r;
  tsp_pkg::state_s st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Derived combinational terms
  logic        cs_stable;
  logic        ck_stable;
  logic        sel_fall;
  logic        sel_rise;
  logic        ck_rise;
  logic        ck_fall;
  logic        sel_act;
  logic        rx_phase;
  logic        conv_done;
  logic [15:0] temp_word;
  logic [15:0] out_word;
  logic        req;

  // Filter: change counts once second and third stages agree
  assign cs_stable = (st_r.cs_s[1] == st_r.cs_s[2]);
  assign ck_stable = (st_r.ck_s[1] == st_r.ck_s[2]);
  assign sel_fall  = cs_stable && st_r.cs_f && !st_r.cs_s[2];
  assign sel_rise  = cs_stable && !st_r.cs_f && st_r.cs_s[2];
  assign ck_rise   = ck_stable && !st_r.ck_f && st_r.ck_s[2];
  assign ck_fall   = ck_stable && st_r.ck_f && !st_r.ck_s[2];
  assign sel_act   = !st_r.cs_f;
  assign rx_phase  = st_r.bit_cnt[4];
  assign conv_done = st_r.busy && (st_r.conv_cnt == CONV_LAST);
  assign req       = AVS_READ || AVS_WRITE;

  // Outgoing word per mode
  assign temp_word = {st_r.result, 2'b11};  // (R18) (R23)
  assign out_word  = (st_r.mode == tsp_pkg::MODE_SHDN) ? {ID_WORD[15:2], 2'b11}  // (R21) (R23)
                                                       : temp_word;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    st_nxt = st_r;

    // Three-stage synchronisers on pins
    st_nxt.cs_s = {st_r.cs_s[1:0], CS_N};
    st_nxt.ck_s = {st_r.ck_s[1:0], SERIAL_CLOCK};
    st_nxt.di_s = {st_r.di_s[1:0], SIO_IN};
    if (cs_stable) begin
      st_nxt.cs_f = st_r.cs_s[2];
    end
    if (ck_stable) begin
      st_nxt.ck_f = st_r.ck_s[2];
    end

    // Converter: runs only in continuous mode, never aborted by a read
    if (st_r.busy) begin  // (R15)
      if (conv_done) begin
        st_nxt.result   = st_r.sample;  // (R17)
        st_nxt.valid    = 1'b1;  // (R14)
        st_nxt.conv_cnt = '0;
        st_nxt.busy     = 1'b0;
      end else begin
        st_nxt.conv_cnt = st_r.conv_cnt + 24'h000001;
      end
    end

    // Idle: output register tracks latest word
    if (!sel_act) begin
      st_nxt.tx_sr       = out_word;  // (R9)
      st_nxt.bit_cnt     = '0;
      st_nxt.rx_cnt      = '0;
      st_nxt.reload_pend = 1'b0;
    end

    // Frame start: drive first bit at once
    if (sel_fall) begin
      st_nxt.bit_cnt     = '0;
      st_nxt.rx_cnt      = '0;
      st_nxt.reload_pend = 1'b0;
      st_nxt.tx_sr       = out_word;
    end

    // Rising serial clock: count, sample input in receive phase
    if (sel_act && ck_rise) begin  // (R1)
      st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;  // (R4) (R10)
      if (rx_phase) begin
        st_nxt.rx_sr = {st_r.rx_sr[6:0], st_r.di_s[2]};  // (R11)
        if (st_r.rx_cnt != PHASE) begin
          st_nxt.rx_cnt = st_r.rx_cnt + 5'h01;
        end
        // Full receive phase ends: apply code, next read follows
        if (st_r.bit_cnt == 5'h1F) begin  // (R22)
          st_nxt.rx_cnt      = '0;
          st_nxt.reload_pend = 1'b1;
          if ({st_r.rx_sr[6:0], st_r.di_s[2]} == `TSP_CODE_SHDN) begin  // (R12)
            st_nxt.mode = tsp_pkg::MODE_SHDN;
          end else if ({st_r.rx_sr[6:0], st_r.di_s[2]} == `TSP_CODE_CONT) begin
            st_nxt.mode = tsp_pkg::MODE_CONT;
          end
        end
      end
    end

    // Falling serial clock: shift out next bit, msb first
    if (sel_act && ck_fall) begin  // (R1)
      if (st_r.reload_pend) begin
        st_nxt.tx_sr       = out_word;  // (R20) (R21)
        st_nxt.reload_pend = 1'b0;
      end else if (!rx_phase && st_r.bit_cnt != 5'h00) begin
        st_nxt.tx_sr = {st_r.tx_sr[14:0], 1'b1};  // (R19)
      end
    end

    // Frame end: decode last eight bits, reload; a running conversion is not restarted
    if (sel_rise) begin  // (R8)
      st_nxt.bit_cnt     = '0;
      st_nxt.reload_pend = 1'b0;
      if (rx_phase && st_r.rx_cnt >= CODE_MIN) begin  // (R11)
        if (st_r.rx_sr == `TSP_CODE_SHDN) begin  // (R12)
          st_nxt.mode = tsp_pkg::MODE_SHDN;
        end else if (st_r.rx_sr == `TSP_CODE_CONT) begin
          st_nxt.mode = tsp_pkg::MODE_CONT;
        end
      end
      st_nxt.rx_cnt = '0;
    end

    // Start a conversion whenever continuous mode is idle
    if (st_nxt.mode == tsp_pkg::MODE_CONT && !st_nxt.busy) begin  // (R16)
      st_nxt.busy     = 1'b1;
      st_nxt.conv_cnt = '0;
    end
    if (st_nxt.mode == tsp_pkg::MODE_SHDN) begin
      st_nxt.busy     = 1'b0;
      st_nxt.conv_cnt = '0;
    end

    // Data line: driven only while selected and transmitting
    st_nxt.sio_oe  = !st_nxt.cs_f && !st_nxt.bit_cnt[4];  // (R5) (R7) (R10)
    st_nxt.sio_out = st_nxt.sio_oe ? st_nxt.tx_sr[15] : 1'b0;

    // Avalon slave: one wait cycle, then the transfer completes
    st_nxt.waitreq = !(req && st_r.waitreq);
    if (req && st_r.waitreq) begin
      case (AVS_ADDRESS)
        `TSP_ADDR_SAMPLE: begin
          st_nxt.rdata = {18'h00000, st_r.sample};
        end
        `TSP_ADDR_STATUS: begin
          st_nxt.rdata                = 32'h00000000;
          st_nxt.rdata[`TSP_ST_SHDN]  = (st_r.mode == tsp_pkg::MODE_SHDN);
          st_nxt.rdata[`TSP_ST_VALID] = st_r.valid;
          st_nxt.rdata[`TSP_ST_BUSY]  = st_r.busy;
          st_nxt.rdata[`TSP_ST_SEL]   = sel_act;
        end
        `TSP_ADDR_RESULT: begin
          st_nxt.rdata = {16'h0000, temp_word};
        end
        default: begin
          st_nxt.rdata = 32'h00000000;
        end
      endcase
    end
    // Write takes effect on the edge where waitrequest is low
    if (AVS_WRITE && !st_r.waitreq && AVS_ADDRESS == `TSP_ADDR_SAMPLE) begin
      if (AVS_BYTEENABLE[0]) begin
        st_nxt.sample[7:0] = AVS_WRITEDATA[7:0];
      end
      if (AVS_BYTEENABLE[1]) begin
        st_nxt.sample[13:8] = AVS_WRITEDATA[13:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st_r.cs_s        <= 3'h7;
      st_r.ck_s        <= 3'h0;
      st_r.di_s        <= 3'h0;
      st_r.cs_f        <= 1'b1;
      st_r.ck_f        <= 1'b0;
      st_r.bit_cnt     <= 5'h00;
      st_r.tx_sr       <= 16'h0000;
      st_r.rx_sr       <= 8'h00;
      st_r.rx_cnt      <= 5'h00;
      st_r.reload_pend <= 1'b0;
      st_r.mode        <= tsp_pkg::MODE_CONT;  // (R14)
      st_r.valid       <= 1'b0;
      st_r.busy        <= 1'b0;
      st_r.conv_cnt    <= 24'h000000;
      st_r.result      <= `TSP_RESULT_RST;
      st_r.sample      <= `TSP_SAMPLE_RST;
      st_r.sio_out     <= 1'b0;
      st_r.sio_oe      <= 1'b0;
      st_r.rdata       <= 32'h00000000;
      st_r.waitreq     <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state flops
  assign SIO_OUT         = st_r.sio_out;
  assign SIO_OE          = st_r.sio_oe;
  assign AVS_READDATA    = st_r.rdata;
  assign AVS_WAITREQUEST = st_r.waitreq;

endmodule : temp_sensor_serial_port

// ---- verif/tsp_chk.sv ----
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// Pin protocol checker
module tsp_chk (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CS_N,
  input wire logic SERIAL_CLOCK,
  input wire logic SIO_OUT,
  input wire logic SIO_OE,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST
);
  logic       sc_q;
  logic       sc_rise;
  logic [4:0] rise_cnt;

  // Serial clock rises counted within a frame
  assign sc_rise = SERIAL_CLOCK && !sc_q;
  always_ff @(posedge SYS_CLK) begin
    sc_q     <= SERIAL_CLOCK;
    rise_cnt <= (RST || CS_N) ? 5'h00 : rise_cnt + 5'(sc_rise);
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  // Frame start and end
  sequence s_open;
    $fell(CS_N);
  endsequence
  sequence s_close;
    $rose(CS_N);
  endsequence

  a_first_bit: assert property (s_open |-> ##[1:7] SIO_OE)
    else $error("no drive after select fall");
  a_close_release: assert property (s_close |-> ##[1:7] !SIO_OE)
    else $error("line held after select rise");
  a_idle_released: assert property (CS_N [*8] |-> !SIO_OE)
    else $error("line driven while idle");
  a_fall_change: assert property (sc_rise && SIO_OE |-> ##2 ($stable(SIO_OUT) || !SIO_OE) [*5])
    else $error("output moved near clock rise");
  a_tx_window: assert property (sc_rise && rise_cnt inside {[5'h01:5'h0F]} |-> SIO_OE)
    else $error("drive lost in send phase");
  a_rx_phase: assert property (sc_rise && rise_cnt == 5'h10 |-> !SIO_OE)
    else $error("drive kept in receive phase");
  a_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |-> ##[1:2] !AVS_WAITREQUEST)
    else $error("bus request not answered");
  a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
endmodule : tsp_chk

// ---- verif/tsp_host.sv ----
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// Host serial master model
module tsp_host (
  input  wire logic   clk,
  input  wire logic   dev_out,
  input  wire logic   dev_oe,
  output logic        cs_n,
  output logic        sclk,
  output logic        line,
  output logic        got,
  output logic [15:0] word
);
  logic drv;
  logic dout;
  logic junk;

  // Line level: device, then host, else a moving pattern
  assign line = dev_oe ? dev_out : (drv ? dout : junk);
  initial begin
    {cs_n, sclk, drv, dout, junk, got, word} = {1'b1, 21'h0};
    forever @(posedge clk) junk <= ~junk;
  end

  // One frame: even phases read a word, odd phases send a code
  task automatic xfer(input int n, input logic [7:0] c1, input logic [7:0] c2);
    logic [7:0] c;
    @(posedge clk) cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      c = ((i / 16) % 4 == 1) ? c1 : c2;
      drv <= (i / 16) % 2 == 1;
      dout <= c[7 - i % 8];
      @(posedge clk) got <= 1'b0;
      repeat (3) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      word <= {word[14:0], line};
      got <= (i / 16) % 2 == 0 && i % 16 == 15;
      sclk <= 1'b0;
    end
    @(posedge clk) got <= 1'b0;
    cs_n <= 1'b1;
    drv <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : xfer
endmodule : tsp_host

// ---- verif/temp_sensor_serial_port_test.sv ----
`timescale 1ns/100ps
`include "tsp_defs.svh"
////////////////////////////////////////////////////////////
// Bench top
module temp_sensor_serial_port_test;
  localparam int          CONV = 200;
  localparam logic [15:0] ID   = 16'h5A40;  // Arbitrary identity value
  logic        SYS_CLK, RST, CS_N, SERIAL_CLOCK, SIO_IN, SIO_OUT, SIO_OE;
  logic        AVS_READ, AVS_WRITE, AVS_WAITREQUEST, got, rd_got;
  logic [3:0]  AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd_val;
  logic [15:0] word, idw;
  logic [13:0] t;
  logic [15:0] q_ser[$];
  logic [31:0] q_reg[$];
  int          num_errors, samples_checked;

  temp_sensor_serial_port #(.CONV_CYCLES(CONV), .ID_WORD(ID)) dut_u (.SYS_CLK(SYS_CLK), .RST(RST),
    .CS_N(CS_N), .SERIAL_CLOCK(SERIAL_CLOCK), .SIO_IN(SIO_IN), .SIO_OUT(SIO_OUT), .SIO_OE(SIO_OE),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));
  tsp_host host_u (.clk(SYS_CLK), .dev_out(SIO_OUT), .dev_oe(SIO_OE), .cs_n(CS_N), .sclk(SERIAL_CLOCK),
    .line(SIO_IN), .got(got), .word(word));

  ////////////////////////////////////////////////////////////
  // Register bus transfer, held until waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    {AVS_ADDRESS, AVS_WRITEDATA, AVS_WRITE, AVS_READ} <= {a, d, wr, !wr};
    do @(posedge SYS_CLK); while (AVS_WAITREQUEST !== 1'b0);
    {rd_val, rd_got, AVS_READ, AVS_WRITE} <= {AVS_READDATA, !wr, 2'b00};
    @(posedge SYS_CLK) rd_got <= 1'b0;
  endtask : bus

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    q_reg.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic ser(input int n, input logic [7:0] c1, c2, input logic [15:0] e1, e2);
    if (n >= 16) q_ser.push_back(e1);
    if (n >= 48) q_ser.push_back(e2);
    host_u.xfer(n, c1, c2);
  endtask : ser

  task automatic cmp_ser(input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t: serial word %h expected %h", $time, g, e);
    end
  endtask : cmp_ser

  task automatic cmp_reg(input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t: register read %h expected %h", $time, g, e);
    end
  endtask : cmp_reg

  task automatic report_and_stop;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////
  // Clock, scoreboard and watchdog
  initial begin
    SYS_CLK = 1'b0;
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end
  always @(posedge SYS_CLK) begin
    if (got) cmp_ser(q_ser.pop_front(), word);
    if (rd_got) cmp_reg(q_reg.pop_front(), rd_val);
  end
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    num_errors++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    {RST, AVS_READ, AVS_WRITE, rd_got, AVS_ADDRESS, AVS_WRITEDATA, rd_val} = {1'b1, 71'h0};
    idw = ID | 16'h0003;
    void'($urandom(32'h0FA16F68));
    repeat (3) @(posedge SYS_CLK);
    RST <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    rd(`TSP_ADDR_RESULT, 32'h3);
    rd(`TSP_ADDR_STATUS, 32'h4);
    rd(4'hC, 32'h0);
    for (int k = 0; k < 4; k++) begin
      t = k == 0 ? 14'h1FFF : k == 1 ? 14'h2000 : 14'($urandom);
      bus(1'b1, `TSP_ADDR_SAMPLE, {18'h0, t});
      repeat (2 * CONV + 20) @(posedge SYS_CLK);
      if (k == 1) host_u.xfer(5, 8'h00, 8'h00);
      ser(16, 8'h00, 8'h00, {t, 2'b11}, 16'h0);
      rd(`TSP_ADDR_RESULT, {16'h0, t, 2'b11});
    end
    rd(`TSP_ADDR_STATUS, 32'h6);
    rd(`TSP_ADDR_SAMPLE, {18'h0, t});
    bus(1'b1, `TSP_ADDR_RESULT, 32'hFFFF);
    rd(`TSP_ADDR_RESULT, {16'h0, t, 2'b11});
    ser(32, 8'hFF, 8'hFF, {t, 2'b11}, 16'h0);
    rd(`TSP_ADDR_STATUS, 32'h3);
    ser(16, 8'h00, 8'h00, idw, 16'h0);
    ser(32, 8'h00, 8'h00, idw, 16'h0);
    repeat (2 * CONV + 20) @(posedge SYS_CLK);
    ser(56, 8'hFF, 8'h00, {t, 2'b11}, idw);
    ser(16, 8'h00, 8'h00, {t, 2'b11}, 16'h0);
    repeat (2) @(posedge SYS_CLK);
    report_and_stop();
  end
endmodule : temp_sensor_serial_port_test

bind temp_sensor_serial_port tsp_chk chk_u (.SYS_CLK(SYS_CLK), .RST(RST), .CS_N(CS_N),
  .SERIAL_CLOCK(SERIAL_CLOCK), .SIO_OUT(SIO_OUT), .SIO_OE(SIO_OE), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST));
